// ==== core/adc_mode_control_register.sv ====
// Mode control register and conversion sequencer of the converter
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module adc_mode_control_register
  import mode_ctrl_pkg::*;
#(
  parameter int DLY4_CYCLES = DLY4_CYC,
  parameter int DLY5_CYCLES = DLY5_CYC,
  parameter int DLY6_CYCLES = DLY6_CYC,
  parameter int DLY7_CYCLES = DLY7_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_channel_switch,
  input wire logic i_single_channel,
  input wire logic i_filter_valid,
  input wire logic i_filter_settled,
  input wire logic i_cal_done,
  input wire logic i_data_read,
  output logic o_filter_reset,
  output logic o_input_hold,
  output logic o_modulator_run,
  output logic o_result_strobe,
  output logic o_cal_start,
  output logic [2:0] o_cal_kind,
  output logic o_ready_n,
  output logic o_standby,
  output logic o_power_down,
  output logic o_ref_enable,
  output logic o_osc_enable,
  output logic o_clk_io_oe,
  output logic o_ext_clk_sel,
  output logic o_crystal_enable
);

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  converter_mode_control_type mode_ff;
  logic [15:0] rdata_ff;
  logic wr_mode;
  logic rd_hit;

  assign wr_mode = i_wr && (i_addr == MODE_CONTROL_ADDR);

  // Reserved bits are masked on write so they can never read back set
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_ff <= converter_mode_control_type'(MODE_CONTROL_RESET);
    end else if (wr_mode) begin
      mode_ff <= converter_mode_control_type'(i_wdata & MODE_CONTROL_WMASK);
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  seq_state_type state_ff;
  seq_state_type nxt_state;
  logic restart_ff;
  logic timer_load;
  logic timer_busy;
  logic timer_done;
  logic [CNT_W-1:0] delay_cycles;
  logic is_cal;
  logic converting_mode;
  logic result_ok;
  logic accept;
  logic single_done;

  assign is_cal = mode_ff.op_mode[2];
  assign converting_mode = (mode_ff.op_mode == MODE_CONTINUOUS) ||
                           (mode_ff.op_mode == MODE_SINGLE);

  // Code 0 arms no wait; the long codes are parameters so a bench can shorten them
  always_comb begin
    unique case (mode_ff.switch_delay)
      3'h0: delay_cycles = '0;
      3'h1: delay_cycles = CNT_W'(DLY1_CYC);
      3'h2: delay_cycles = CNT_W'(DLY2_CYC);
      3'h3: delay_cycles = CNT_W'(DLY3_CYC);
      3'h4: delay_cycles = CNT_W'(DLY4_CYCLES);
      3'h5: delay_cycles = CNT_W'(DLY5_CYCLES);
      3'h6: delay_cycles = CNT_W'(DLY6_CYCLES);
      3'h7: delay_cycles = CNT_W'(DLY7_CYCLES);
    endcase
  end

  // Unsettled outputs are dropped only with a single active channel
  assign result_ok = !(mode_ff.settled_rate_only && i_single_channel) ||
                     i_filter_settled;
  assign accept = (state_ff == ST_RUN) && !is_cal && i_filter_valid && result_ok;
  assign single_done = accept && (mode_ff.op_mode == MODE_SINGLE);

  // Restart runs one cycle after the write so new settings are in place
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= wr_mode;
    end
  end

  // A single conversion that ends with a switch stays ended, no wait is armed
  assign timer_load = (state_ff == ST_RUN) && converting_mode && i_channel_switch &&
                      !single_done;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (restart_ff && (converting_mode || is_cal)) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (timer_load && delay_cycles != '0) begin
          nxt_state = ST_SETTLE;
        end else if (is_cal && i_cal_done) begin
          nxt_state = ST_IDLE;
        end else if (single_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_SETTLE: begin
        if (timer_done) begin
          nxt_state = ST_RUN;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || wr_mode) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // A mode write aborts any running wait so a new delay code starts clean
  settle_timer #(
    .WIDTH(CNT_W)
  ) u_settle_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(timer_load),
    .i_abort(wr_mode),
    .i_count(delay_cycles),
    .o_busy(timer_busy),
    .o_done(timer_done)
  );

  // ---------------------------------------------------------------
  // Ready flag
  // ---------------------------------------------------------------
  logic ready_n_ff;
  logic cal_finish;

  assign cal_finish = (state_ff == ST_RUN) && is_cal && i_cal_done;

  // A fresh result beats a data read landing in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst || wr_mode) begin
      ready_n_ff <= 1'b1;
    end else if (accept || cal_finish) begin
      ready_n_ff <= 1'b0;
    end else if (i_data_read) begin
      ready_n_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Converter control outputs
  // ---------------------------------------------------------------
  logic filter_reset_ff;
  logic input_hold_ff;
  logic run_ff;
  logic strobe_ff;
  logic cal_start_ff;
  logic [2:0] cal_kind_ff;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      filter_reset_ff <= 1'b0;
      cal_start_ff <= 1'b0;
    end else begin
      filter_reset_ff <= wr_mode;
      cal_start_ff <= (state_ff == ST_IDLE) && restart_ff && is_cal;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      input_hold_ff <= 1'b0;
      run_ff <= 1'b0;
      strobe_ff <= 1'b0;
      cal_kind_ff <= 3'h0;
    end else begin
      input_hold_ff <= (nxt_state == ST_SETTLE) && !wr_mode;
      run_ff <= (nxt_state != ST_IDLE) && !wr_mode;
      strobe_ff <= accept && !wr_mode;
      // Copied every cycle; it only matters beside the start pulse
      cal_kind_ff <= mode_ff.op_mode;
    end
  end

  // ---------------------------------------------------------------
  // Power, reference and clock controls
  // ---------------------------------------------------------------
  logic standby_ff;
  logic power_down_ff;
  logic ref_ff;
  logic osc_ff;
  logic clk_oe_ff;
  logic ext_ff;
  logic xtal_ff;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      standby_ff <= 1'b0;
      power_down_ff <= 1'b0;
      ref_ff <= 1'b0;
    end else begin
      standby_ff <= (mode_ff.op_mode == MODE_STANDBY);
      power_down_ff <= (mode_ff.op_mode == MODE_POWER_DOWN);
      // Power-down drops the reference regardless of the enable bit
      ref_ff <= mode_ff.ref_enable && (mode_ff.op_mode != MODE_POWER_DOWN);
    end
  end

  // Oscillator follows the select bits, no separate enable needed
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      osc_ff <= 1'b1;
      clk_oe_ff <= 1'b0;
      ext_ff <= 1'b0;
      xtal_ff <= 1'b0;
    end else begin
      osc_ff <= (mode_ff.conversion_clock_select == CLK_INT_OSC) ||
                (mode_ff.conversion_clock_select == CLK_INT_OUT);
      clk_oe_ff <= (mode_ff.conversion_clock_select == CLK_INT_OUT);
      ext_ff <= (mode_ff.conversion_clock_select == CLK_EXT_IN);
      xtal_ff <= (mode_ff.conversion_clock_select == CLK_CRYSTAL);
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  assign rd_hit = i_rd && (i_addr == MODE_CONTROL_ADDR);

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  logic [15:0] status_word;

  // Timer busy, sequencer state, calibration flag and ready flag, low bit last
  assign status_word = {11'h000, timer_busy, state_ff, is_cal, ready_n_ff};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_ff <= READ_ZERO;
    end else if (rd_hit) begin
      rdata_ff <= 16'(mode_ff) & MODE_CONTROL_WMASK;
    end else if (i_rd && i_addr == SEQ_STATUS_ADDR) begin
      rdata_ff <= status_word;
    end else begin
      // Unmapped reads and idle cycles return zero
      rdata_ff <= READ_ZERO;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_filter_reset = filter_reset_ff;
  assign o_input_hold = input_hold_ff;
  assign o_modulator_run = run_ff;
  assign o_result_strobe = strobe_ff;
  assign o_cal_start = cal_start_ff;
  assign o_cal_kind = cal_kind_ff;
  assign o_ready_n = ready_n_ff;
  assign o_standby = standby_ff;
  assign o_power_down = power_down_ff;
  assign o_ref_enable = ref_ff;
  assign o_osc_enable = osc_ff;
  assign o_clk_io_oe = clk_oe_ff;
  assign o_ext_clk_sel = ext_ff;
  assign o_crystal_enable = xtal_ff;

endmodule // adc_mode_control_register

// ==== core/mode_ctrl_pkg.sv ====
// Shared constants and types for the converter mode control block
package mode_ctrl_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] MODE_CONTROL_ADDR = 6'h01;
  localparam logic [ADDR_W-1:0] SEQ_STATUS_ADDR = 6'h08;
  localparam logic [15:0] MODE_CONTROL_RESET = 16'h2000;
  localparam logic [15:0] MODE_CONTROL_WMASK = 16'hA77C;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int REF_EN_BIT = 15;
  localparam int SETTLED_BIT = 13;
  localparam int DELAY_LSB = 8;
  localparam int MODE_LSB = 4;
  localparam int CLKSEL_LSB = 2;

  // ---------------------------------------------------------------
  // Field encodings
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_CONTINUOUS = 3'h0,
    MODE_SINGLE     = 3'h1,
    MODE_STANDBY    = 3'h2,
    MODE_POWER_DOWN = 3'h3,
    MODE_CAL_INT_OFS = 3'h4,
    MODE_CAL_INT_GAIN = 3'h5,
    MODE_CAL_SYS_OFS = 3'h6,
    MODE_CAL_SYS_GAIN = 3'h7
  } op_mode_type;

  typedef enum logic [1:0] {
    CLK_INT_OSC  = 2'h0,
    CLK_INT_OUT  = 2'h1,
    CLK_EXT_IN   = 2'h2,
    CLK_CRYSTAL  = 2'h3
  } clk_sel_type;

  typedef struct packed {
    logic       ref_enable;
    logic       rsvd14;
    logic       settled_rate_only;
    logic [1:0] rsvd12;
    logic [2:0] switch_delay;
    logic       rsvd7;
    op_mode_type op_mode;
    clk_sel_type conversion_clock_select;
    logic [1:0] rsvd1;
  } converter_mode_control_type;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int DLY1_NS = 16_000;
  localparam int DLY2_NS = 64_000;
  localparam int DLY3_NS = 160_000;
  localparam int DLY4_NS = 400_000;
  localparam int DLY5_NS = 800_000;
  localparam int DLY6_NS = 3_000_000;
  localparam int DLY7_NS = 4_000_000;
  localparam int DLY1_CYC = (DLY1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY2_CYC = (DLY2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY3_CYC = (DLY3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY4_CYC = (DLY4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY5_CYC = (DLY5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY6_CYC = (DLY6_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY7_CYC = (DLY7_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 17;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN    = 2'b11
  } seq_state_type;

endpackage

// ==== core/settle_timer.sv ====
// Down-counter that times the wait after a channel switch
`timescale 1ns/1ps
module settle_timer #(
  parameter int WIDTH = 17
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic i_abort,
  input wire logic [WIDTH-1:0] i_count,
  output logic o_busy,
  output logic o_done
);

  logic [WIDTH-1:0] count_ff;
  logic busy_ff;
  logic done_ff;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  // Abort beats load so a restart never leaves a stale wait running
  always_ff @(posedge i_clk) begin
    if (i_rst || i_abort) begin
      count_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (i_load) begin
      count_ff <= i_count;
      busy_ff <= (i_count != '0);
      done_ff <= (i_count == '0);
    end else if (busy_ff) begin
      count_ff <= count_ff - WIDTH'(1);
      busy_ff <= (count_ff != WIDTH'(1));
      done_ff <= (count_ff == WIDTH'(1));
    end else begin
      done_ff <= 1'b0;
    end
  end

  assign o_busy = busy_ff;
  assign o_done = done_ff;

endmodule // settle_timer

// ==== sim/adc_mode_control_register_props.sv ====
// Port checks for the converter mode control block
`timescale 1ns/1ps
module adc_mode_control_register_props
  import mode_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic i_channel_switch,
  input wire logic o_filter_reset,
  input wire logic o_input_hold,
  input wire logic o_result_strobe,
  input wire logic o_ready_n,
  input wire logic o_standby,
  input wire logic o_power_down,
  input wire logic o_ref_enable,
  input wire logic o_osc_enable,
  input wire logic o_clk_io_oe,
  input wire logic o_ext_clk_sel,
  input wire logic o_crystal_enable
);
  logic wr_mode;
  assign wr_mode = i_wr && (i_addr == MODE_CONTROL_ADDR);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // -----------------------------------------
  // Filter reset and ready follow the write one edge on, register-driven controls two edges on
  // -----------------------------------------
  a_write_resets_filter: assert property (wr_mode |=> o_filter_reset)
    else $error("no filter reset after mode write");
  a_write_clears_ready: assert property (wr_mode |=> o_ready_n)
    else $error("ready not cleared by mode write");
  a_rsvd_read_zero: assert property ((i_rd && i_addr == MODE_CONTROL_ADDR) |=>
    (o_rdata & ~MODE_CONTROL_WMASK) == 16'h0000) else $error("reserved bit reads one");
  a_ref_follows_bit: assert property (wr_mode |-> ##2 o_ref_enable ==
    ($past(i_wdata[15], 2) && $past(i_wdata[6:4], 2) != 3'h3)) else $error("ref enable wrong");
  a_osc_on_internal: assert property (wr_mode |-> ##2
    o_osc_enable == !$past(i_wdata[3], 2)) else $error("oscillator enable wrong");
  a_clock_pin_select: assert property (wr_mode |-> ##2
    o_clk_io_oe == ($past(i_wdata[3:2], 2) == 2'h1) &&
    o_ext_clk_sel == ($past(i_wdata[3:2], 2) == 2'h2) &&
    o_crystal_enable == ($past(i_wdata[3:2], 2) == 2'h3)) else $error("clock pins wrong");
  a_mode_levels: assert property (wr_mode |-> ##2
    o_standby == ($past(i_wdata[6:4], 2) == 3'h2) &&
    o_power_down == ($past(i_wdata[6:4], 2) == 3'h3)) else $error("mode levels wrong");
  a_result_shows_ready: assert property (o_result_strobe |-> !o_ready_n)
    else $error("result without ready");
  a_hold_after_switch: assert property ($rose(o_input_hold) |-> $past(i_channel_switch))
    else $error("hold without channel switch");
endmodule // adc_mode_control_register_props

bind adc_mode_control_register adc_mode_control_register_props u_props (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_channel_switch(i_channel_switch),
  .o_filter_reset(o_filter_reset), .o_input_hold(o_input_hold),
  .o_result_strobe(o_result_strobe), .o_ready_n(o_ready_n), .o_standby(o_standby),
  .o_power_down(o_power_down), .o_ref_enable(o_ref_enable), .o_osc_enable(o_osc_enable),
  .o_clk_io_oe(o_clk_io_oe), .o_ext_clk_sel(o_ext_clk_sel),
  .o_crystal_enable(o_crystal_enable)
);

// ==== sim/test_adc_mode_control_register.sv ====
// Self-checking bench for the converter mode control block
`timescale 1ns/1ps
module test_adc_mode_control_register;
  import mode_ctrl_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_single_channel = 1'b1;
  logic i_filter_settled = 1'b0;
  logic [3:0] pls = 4'h0;
  logic [15:0] o_rdata;
  logic [2:0] o_cal_kind;
  logic o_filter_reset, o_input_hold, o_modulator_run, o_result_strobe, o_cal_start;
  logic o_ready_n, o_standby, o_power_down, o_ref_enable, o_osc_enable;
  logic o_clk_io_oe, o_ext_clk_sel, o_crystal_enable;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int cal_cnt = 0;
  int base, n;
  logic [2:0] cal_kind = 3'h0;
  logic [2:0] dcode [4] = '{3'h0, 3'h1, 3'h4, 3'h7};
  int dcyc [4] = '{0, DLY1_CYC + 1, 21, 51};

  // Long delays shortened to keep the run brief
  adc_mode_control_register #(.DLY4_CYCLES(20), .DLY5_CYCLES(30), .DLY6_CYCLES(40),
    .DLY7_CYCLES(50)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_channel_switch(pls[0]),
    .i_single_channel(i_single_channel), .i_filter_valid(pls[1]),
    .i_filter_settled(i_filter_settled), .i_cal_done(pls[2]), .i_data_read(pls[3]),
    .o_filter_reset(o_filter_reset), .o_input_hold(o_input_hold),
    .o_modulator_run(o_modulator_run), .o_result_strobe(o_result_strobe),
    .o_cal_start(o_cal_start), .o_cal_kind(o_cal_kind), .o_ready_n(o_ready_n),
    .o_standby(o_standby), .o_power_down(o_power_down), .o_ref_enable(o_ref_enable),
    .o_osc_enable(o_osc_enable), .o_clk_io_oe(o_clk_io_oe), .o_ext_clk_sel(o_ext_clk_sel),
    .o_crystal_enable(o_crystal_enable)
  );

  always #25 i_clk = ~i_clk;

  // Calibration start is a one-cycle pulse, so it is latched here
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_cal_start === 1'b1) begin
      cal_cnt <= cal_cnt + 1;
      cal_kind <= o_cal_kind;
    end
    if (cyc == 5000) begin
      bad_count++;
      wrap_up();
    end
  end

  // -----------------------------------------
  // Access tasks
  // -----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= MODE_CONTROL_ADDR;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(negedge i_clk);
    chk(o_filter_reset, 1'b1);
    chk(o_ready_n, 1'b1);
    repeat (4) @(negedge i_clk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_rdata, e);
  endtask

  task automatic pulse(input logic [3:0] p);
    @(posedge i_clk);
    pls <= p;
    @(posedge i_clk);
    pls <= 4'h0;
    @(negedge i_clk);
  endtask

  task automatic res(input logic s, input logic e);
    @(posedge i_clk);
    i_filter_settled <= s;
    pls <= 4'h2;
    @(posedge i_clk);
    pls <= 4'h0;
    @(negedge i_clk);
    chk(o_result_strobe, e);
    if (e) chk(o_ready_n, 1'b0);
  endtask

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // -----------------------------------------
  // Main sequence
  // -----------------------------------------
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    chk(o_ready_n, 1'b1);
    chk(o_ref_enable, 1'b0);
    chk(o_osc_enable, 1'b1);
    rd(MODE_CONTROL_ADDR, 16'h2000);
    rd(6'h20, 16'h0000);
    rd(SEQ_STATUS_ADDR, 16'h0001);
    wr(16'hFFFF);
    rd(MODE_CONTROL_ADDR, 16'hA77C);
    for (int m = 0; m < 8; m++) begin
      base = cal_cnt;
      wr({9'h140, m[2:0], m[1:0], 2'b00});
      chk(o_standby, m == 2);
      chk(o_power_down, m == 3);
      chk(o_modulator_run, m != 2 && m != 3);
      chk(o_ref_enable, m != 3);
      chk(o_osc_enable, m[1] == 1'b0);
      chk(o_clk_io_oe, m[1:0] == 2'h1);
      chk(o_ext_clk_sel, m[1:0] == 2'h2);
      chk(o_crystal_enable, m[1:0] == 2'h3);
      chk(16'(cal_cnt - base), m > 3);
      if (m > 3) begin
        chk(cal_kind, m[2:0]);
        rd(SEQ_STATUS_ADDR, 16'h000F);
        pulse(4'h4);
        chk(o_ready_n, 1'b0);
        rd(SEQ_STATUS_ADDR, 16'h0002);
        pulse(4'h8);
        chk(o_ready_n, 1'b1);
      end
    end
    wr(16'h2000);
    res(1'b0, 1'b0);
    res(1'b1, 1'b1);
    @(posedge i_clk);
    i_single_channel <= 1'b0;
    res(1'b0, 1'b1);
    @(posedge i_clk);
    i_single_channel <= 1'b1;
    wr(16'h0000);
    res(1'b0, 1'b1);
    wr(16'h2010);
    res(1'b1, 1'b1);
    res(1'b1, 1'b0);
    wr(16'h2010);
    res(1'b1, 1'b1);
    for (int k = 0; k < 4; k++) begin
      wr({5'h04, dcode[k], 8'h00});
      pulse(4'h1);
      n = 0;
      while (o_input_hold === 1'b1 && n < 2000) begin
        n++;
        @(negedge i_clk);
      end
      chk(n[15:0], dcyc[k][15:0]);
    end
    wrap_up();
  end
endmodule // test_adc_mode_control_register
